// ==== design/ivp_pkg.sv ====
// shared constants and types of the interrupt vector priority map
package ivp_pkg;

    // ********************************************************************
    // source list, in ascending vector number order
    // ********************************************************************
    localparam int NUM_SRC   = 27;
    localparam int VEC_W     = 6;
    localparam int ADDR_W    = 16;
    localparam int DATA_W    = 8;
    localparam int REG_AW    = 4;
    localparam int NUM_PIN   = 5;
    localparam int NUM_TMR   = 15;
    localparam int NUM_SER   = 4;

    // bit positions of the sources in the flat request vector
    localparam int SRC_NMI   = 0;
    localparam int SRC_PIN0  = 1;
    localparam int SRC_WDT   = 6;
    localparam int SRC_TMR0  = 7;
    localparam int SRC_SER0  = 22;
    localparam int SRC_CONV  = 26;

    localparam logic [VEC_W-1:0] SRC_VEC [0:NUM_SRC-1] = '{
        6'h07,                                  // non-maskable
        6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10,      // pins 0..4
        6'h14,                                  // watchdog interval
        6'h18, 6'h19, 6'h1A,                    // timer 0
        6'h1C, 6'h1D, 6'h1E,                    // timer 1
        6'h20, 6'h21, 6'h22,                    // timer 2
        6'h24, 6'h25, 6'h26,                    // timer 3
        6'h28, 6'h29, 6'h2A,                    // timer 4
        6'h34, 6'h35, 6'h36, 6'h37,             // serial interface
        6'h3C                                   // converter end
    };

    // priority select code: 0..7 bit of select a, 8..15 bit of select b
    localparam logic [4:0] PSEL_NONE = 5'h10;
    localparam logic [4:0] SRC_PSEL [0:NUM_SRC-1] = '{
        5'h10,
        5'h07, 5'h06, 5'h05, 5'h05, 5'h04,
        5'h03,
        5'h02, 5'h02, 5'h02,
        5'h01, 5'h01, 5'h01,
        5'h00, 5'h00, 5'h00,
        5'h0F, 5'h0F, 5'h0F,
        5'h0E, 5'h0E, 5'h0E,
        5'h0B, 5'h0B, 5'h0B, 5'h0B,
        5'h09
    };

    // ********************************************************************
    // vector slot layout
    // ********************************************************************
    localparam int ADV_SLOT_SHIFT  = 2;
    localparam int NORM_SLOT_SHIFT = 1;

    // ********************************************************************
    // register map (word index on the register port)
    // ********************************************************************
    localparam logic [REG_AW-1:0] REG_PSEL_A    = 4'h0;
    localparam logic [REG_AW-1:0] REG_PSEL_B    = 4'h1;
    localparam logic [REG_AW-1:0] REG_CTRL      = 4'h2;
    localparam logic [REG_AW-1:0] REG_EVT_STAT  = 4'h3;
    localparam logic [REG_AW-1:0] REG_EVT_MASK  = 4'h4;
    localparam logic [REG_AW-1:0] REG_CUR_VEC   = 4'h5;
    localparam logic [REG_AW-1:0] REG_LAST_VEC  = 4'h6;
    localparam logic [REG_AW-1:0] REG_PEND_0    = 4'h7;
    localparam logic [REG_AW-1:0] REG_PEND_1    = 4'h8;
    localparam logic [REG_AW-1:0] REG_PEND_2    = 4'h9;
    localparam logic [REG_AW-1:0] REG_PEND_3    = 4'hA;

    localparam logic [DATA_W-1:0] PSEL_A_RST    = 8'h00;
    localparam logic [DATA_W-1:0] PSEL_B_RST    = 8'h00;
    localparam logic              CTRL_ADV_RST  = 1'b1;
    localparam int                CTRL_ADV_BIT  = 0;

    // event bits
    localparam int NUM_EVT       = 3;
    localparam int EVT_TAKEN     = 0;
    localparam int EVT_NMI_TAKEN = 1;
    localparam int EVT_SPURIOUS  = 2;

    // current vector readout fields
    localparam int CUR_VALID_BIT = 7;
    localparam int CUR_LEVEL_BIT = 6;

    // ********************************************************************
    // types
    // ********************************************************************
    typedef struct packed {
        logic                 valid;
        logic                 nmi;
        logic                 level;
        logic [VEC_W-1:0]     vec;
    } ivp_pick_s;

    typedef struct packed {
        logic                 nmi;
        logic [NUM_PIN-1:0]   pin;
        logic                 watchdog;
        logic [NUM_TMR-1:0]   timer;
        logic [NUM_SER-1:0]   serial;
        logic                 converter;
    } ivp_req_s;

endpackage

// ==== design/ivp_arbiter.sv ====
// fixed-order arbiter with two promotable priority levels
`timescale 1ns/100ps
`default_nettype none

module ivp_arbiter
    import ivp_pkg::*;
(
    input  wire logic [NUM_SRC-1:0] i_req,
    input  wire logic [DATA_W-1:0]  i_psel_a,
    input  wire logic [DATA_W-1:0]  i_psel_b,
    output ivp_pick_s               o_pick
);

    logic [NUM_SRC-1:0] hi;

    // ********************************************************************
    // level of each source from its select bit
    // ********************************************************************
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g = g + 1) begin : g_lvl
            if (SRC_PSEL[g] == PSEL_NONE) begin : g_none
                assign hi[g] = 1'b0;
            end else if (SRC_PSEL[g][3] == 1'b0) begin : g_a
                assign hi[g] = i_psel_a[SRC_PSEL[g][2:0]];
            end else begin : g_b
                assign hi[g] = i_psel_b[SRC_PSEL[g][2:0]];
            end
        end
    endgenerate

    // ********************************************************************
    // pick: nmi, then level 1 by vector, then level 0 by vector
    // ********************************************************************
    always_comb begin
        o_pick = '0;
        for (int i = NUM_SRC - 1; i >= 0; i = i - 1) begin
            if (i_req[i] && !hi[i] && !o_pick.level) begin
                o_pick.valid = 1'b1;
                o_pick.vec   = SRC_VEC[i];
            end
        end
        for (int i = NUM_SRC - 1; i >= 0; i = i - 1) begin
            if (i_req[i] && hi[i]) begin
                o_pick.valid = 1'b1;
                o_pick.level = 1'b1;
                o_pick.vec   = SRC_VEC[i];
            end
        end
        if (i_req[SRC_NMI]) begin
            o_pick.valid = 1'b1;
            o_pick.nmi   = 1'b1;
            o_pick.level = 1'b1;
            o_pick.vec   = SRC_VEC[SRC_NMI];
        end
    end

endmodule

`default_nettype wire

// ==== design/ivp_vec_addr.sv ====
// vector number to vector table address
`timescale 1ns/100ps
`default_nettype none

module ivp_vec_addr
    import ivp_pkg::*;
(
    input  wire logic [VEC_W-1:0]  i_vec,
    input  wire logic              i_adv,
    output logic      [ADDR_W-1:0] o_addr
);

    logic [ADDR_W-1:0] vec_wide;

    assign vec_wide = ADDR_W'(i_vec);

    // four-byte slots in advanced mode, two-byte slots in normal mode
    always_comb begin
        if (i_adv) begin
            o_addr = vec_wide << ADV_SLOT_SHIFT;
        end else begin
            o_addr = vec_wide << NORM_SLOT_SHIFT;
        end
    end

endmodule

`default_nettype wire

// ==== design/ivp_top.sv ====
// interrupt vector priority map: arbitration, vector output, registers
// What this block does
// - each source has a fixed vector; advanced slot is vec*4, normal is vec*2
// - vector addresses are the low sixteen address bits only
// - by default the smaller vector number wins
// - all but the non-maskable source are reordered by the two select registers
// - after reset no source is promoted; default order applies
// - timer 0 uses vectors 24..26 under select a bit 2
// - timer 1 uses vectors 28..30 under select a bit 1
// - timer 2 uses vectors 32..34 under select a bit 0
// - timer 3 uses vectors 36..38 under select b bit 7
// - timer 4 uses vectors 40..42 under select b bit 6
// - serial interface uses vectors 52..55 under select b bit 3
// - non-maskable source always accepted, vector 7
// - pins 0..4 use vectors 12..16 in order
// - select bit one gives level 1, zero gives level 0
// - equal levels resolve by vector order, losers stay pending
`timescale 1ns/100ps
`default_nettype none

module ivp_top
    import ivp_pkg::*;
(
    input  wire logic              I_CLK,
    input  wire logic              I_RST_B,
    input  wire logic              I_NMI_REQ,
    input  wire logic [NUM_PIN-1:0] I_PIN_REQ,
    input  wire logic              I_WATCHDOG_REQ,
    input  wire logic [NUM_TMR-1:0] I_TIMER_REQ,
    input  wire logic [NUM_SER-1:0] I_SERIAL_REQ,
    input  wire logic              I_CONVERTER_REQ,
    input  wire logic              I_VEC_ACK,
    input  wire logic [REG_AW-1:0] I_REG_ADDR,
    input  wire logic [DATA_W-1:0] I_REG_WDATA,
    input  wire logic              I_REG_WR,
    input  wire logic              I_REG_RD,
    output logic      [DATA_W-1:0] O_REG_RDATA,
    output logic                   O_IRQ_VALID,
    output logic                   O_IRQ_NMI,
    output logic                   O_IRQ_LEVEL,
    output logic      [VEC_W-1:0]  O_VECTOR_NUM,
    output logic      [ADDR_W-1:0] O_VECTOR_ADDR,
    output logic                   O_INT
);

    // ********************************************************************
    // state
    // ********************************************************************
    typedef struct packed {
        logic [DATA_W-1:0]  psel_a;
        logic [DATA_W-1:0]  psel_b;
        logic               adv_mode;
        logic [NUM_EVT-1:0] evt_stat;
        logic [NUM_EVT-1:0] evt_mask;
        logic [VEC_W-1:0]   last_vec;
        logic               last_valid;
        logic               irq_valid;
        logic               irq_nmi;
        logic               irq_level;
        logic [VEC_W-1:0]   vec;
        logic [ADDR_W-1:0]  addr;
        logic               intr;
        logic [DATA_W-1:0]  rdata;
    } ivp_state_s;

    localparam ivp_state_s ST_RST = '{
        psel_a     : PSEL_A_RST,
        psel_b     : PSEL_B_RST,
        adv_mode   : CTRL_ADV_RST,
        evt_stat   : 3'h0,
        evt_mask   : 3'h0,
        last_vec   : 6'h00,
        last_valid : 1'b0,
        irq_valid  : 1'b0,
        irq_nmi    : 1'b0,
        irq_level  : 1'b0,
        vec        : 6'h00,
        addr       : 16'h0000,
        intr       : 1'b0,
        rdata      : 8'h00
    };

    ivp_state_s         st;
    ivp_state_s         next_st;

    ivp_req_s           req;
    logic [NUM_SRC-1:0] req_flat;
    ivp_pick_s          pick;
    logic [ADDR_W-1:0]  pick_addr;
    logic [NUM_EVT-1:0] evt_set;
    logic [NUM_EVT-1:0] evt_clr;
    logic [DATA_W-1:0]  rd_mux;
    logic [31:0]        pend_word;

    // ********************************************************************
    // request gathering
    // ********************************************************************
    assign req.nmi       = I_NMI_REQ;
    assign req.pin       = I_PIN_REQ;
    assign req.watchdog  = I_WATCHDOG_REQ;
    assign req.timer     = I_TIMER_REQ;
    assign req.serial    = I_SERIAL_REQ;
    assign req.converter = I_CONVERTER_REQ;

    // flat order follows ascending vector numbers; reserved vectors have no entry
    always_comb begin
        req_flat                                = '0;
        req_flat[SRC_NMI]                       = req.nmi;
        req_flat[SRC_PIN0 +: NUM_PIN]           = req.pin;
        req_flat[SRC_WDT]                       = req.watchdog;
        req_flat[SRC_TMR0 +: NUM_TMR]           = req.timer;
        req_flat[SRC_SER0 +: NUM_SER]           = req.serial;
        req_flat[SRC_CONV]                      = req.converter;
    end

    // ********************************************************************
    // arbitration and address forming
    // ********************************************************************
    ivp_arbiter u_arbiter (
        .i_req    (req_flat),
        .i_psel_a (st.psel_a),
        .i_psel_b (st.psel_b),
        .o_pick   (pick)
    );

    ivp_vec_addr u_vec_addr (
        .i_vec  (pick.vec),
        .i_adv  (st.adv_mode),
        .o_addr (pick_addr)
    );

    // ********************************************************************
    // events: set by the core's acknowledge, cleared by writing one
    // ********************************************************************
    always_comb begin
        evt_set                 = '0;
        evt_set[EVT_TAKEN]      = I_VEC_ACK && st.irq_valid;
        evt_set[EVT_NMI_TAKEN]  = I_VEC_ACK && st.irq_valid && st.irq_nmi;
        evt_set[EVT_SPURIOUS]   = I_VEC_ACK && !st.irq_valid;
        evt_clr                 = '0;
        if (I_REG_WR && I_REG_ADDR == REG_EVT_STAT) begin
            evt_clr = I_REG_WDATA[NUM_EVT-1:0];
        end
    end

    // ********************************************************************
    // read mux
    // ********************************************************************
    assign pend_word = 32'(req_flat);

    always_comb begin
        rd_mux = '0;
        case (I_REG_ADDR)
            REG_PSEL_A: begin
                rd_mux = st.psel_a;
            end
            REG_PSEL_B: begin
                rd_mux = st.psel_b;
            end
            REG_CTRL: begin
                rd_mux[CTRL_ADV_BIT] = st.adv_mode;
            end
            REG_EVT_STAT: begin
                rd_mux[NUM_EVT-1:0] = st.evt_stat;
            end
            REG_EVT_MASK: begin
                rd_mux[NUM_EVT-1:0] = st.evt_mask;
            end
            REG_CUR_VEC: begin
                rd_mux[VEC_W-1:0]    = st.vec;
                rd_mux[CUR_LEVEL_BIT] = st.irq_level;
                rd_mux[CUR_VALID_BIT] = st.irq_valid;
            end
            REG_LAST_VEC: begin
                rd_mux[VEC_W-1:0]    = st.last_vec;
                rd_mux[CUR_VALID_BIT] = st.last_valid;
            end
            REG_PEND_0: begin
                rd_mux = pend_word[7:0];
            end
            REG_PEND_1: begin
                rd_mux = pend_word[15:8];
            end
            REG_PEND_2: begin
                rd_mux = pend_word[23:16];
            end
            REG_PEND_3: begin
                rd_mux = pend_word[31:24];
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    // ********************************************************************
    // next state
    // ********************************************************************
    always_comb begin
        next_st = st;

        // unused select bits are still stored and read back
        if (I_REG_WR) begin
            case (I_REG_ADDR)
                REG_PSEL_A: begin
                    next_st.psel_a = I_REG_WDATA;
                end
                REG_PSEL_B: begin
                    next_st.psel_b = I_REG_WDATA;
                end
                REG_CTRL: begin
                    next_st.adv_mode = I_REG_WDATA[CTRL_ADV_BIT];
                end
                REG_EVT_MASK: begin
                    next_st.evt_mask = I_REG_WDATA[NUM_EVT-1:0];
                end
                default: begin
                    next_st.adv_mode = st.adv_mode;
                end
            endcase
        end

        // set wins over a clear in the same cycle
        next_st.evt_stat = (st.evt_stat & ~evt_clr) | evt_set;

        if (I_VEC_ACK && st.irq_valid) begin
            next_st.last_vec   = st.vec;
            next_st.last_valid = 1'b1;
        end

        // losers are not cleared; their lines stay up until their own source drops them
        next_st.irq_valid = pick.valid;
        next_st.irq_nmi   = pick.nmi;
        next_st.irq_level = pick.level;
        next_st.vec       = pick.vec;
        next_st.addr      = pick_addr;

        next_st.intr = |(next_st.evt_stat & next_st.evt_mask);

        if (I_REG_RD) begin
            next_st.rdata = rd_mux;
        end else begin
            next_st.rdata = '0;
        end
    end

    // ********************************************************************
    // registers
    // ********************************************************************
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            st <= ST_RST;
        end else begin
            st <= next_st;
        end
    end

    // ********************************************************************
    // outputs
    // ********************************************************************
    assign O_REG_RDATA   = st.rdata;
    assign O_IRQ_VALID   = st.irq_valid;
    assign O_IRQ_NMI     = st.irq_nmi;
    assign O_IRQ_LEVEL   = st.irq_level;
    assign O_VECTOR_NUM  = st.vec;
    assign O_VECTOR_ADDR = st.addr;
    assign O_INT         = st.intr;

endmodule

`default_nettype wire

// ==== test/ivp_top_properties.sv ====
// concurrent checks on the ports of the vector priority map
`timescale 1ns/100ps
`default_nettype none

module ivp_top_properties
    import ivp_pkg::*;
(
    input wire logic               I_CLK,
    input wire logic               I_RST_B,
    input wire logic               I_NMI_REQ,
    input wire logic [NUM_PIN-1:0] I_PIN_REQ,
    input wire logic               I_WATCHDOG_REQ,
    input wire logic [NUM_TMR-1:0] I_TIMER_REQ,
    input wire logic [NUM_SER-1:0] I_SERIAL_REQ,
    input wire logic               I_CONVERTER_REQ,
    input wire logic               I_VEC_ACK,
    input wire logic               I_REG_WR,
    input wire logic               I_REG_RD,
    input wire logic [DATA_W-1:0]  O_REG_RDATA,
    input wire logic               O_IRQ_VALID,
    input wire logic               O_IRQ_NMI,
    input wire logic               O_IRQ_LEVEL,
    input wire logic [VEC_W-1:0]   O_VECTOR_NUM,
    input wire logic [ADDR_W-1:0]  O_VECTOR_ADDR,
    input wire logic               O_INT
);
    // ********
    // helpers
    // ********
    logic [26:0] flat;
    logic        any_req;
    assign flat    = {I_NMI_REQ, I_PIN_REQ, I_WATCHDOG_REQ, I_TIMER_REQ, I_SERIAL_REQ, I_CONVERTER_REQ};
    assign any_req = |flat;

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_B);

    // ********
    // checks
    // ********
    nmi_wins_a: assert property ($past(I_RST_B) && $past(I_NMI_REQ)
        |-> O_IRQ_NMI && O_IRQ_LEVEL && O_VECTOR_NUM == 6'h07) else $error("nmi request did not win");
    idle_output_a: assert property ($past(I_RST_B) && !$past(any_req)
        |-> !O_IRQ_VALID && O_VECTOR_NUM == 6'h00) else $error("vector shown with no request");
    valid_follows_a: assert property ($past(I_RST_B) && $past(any_req) |-> O_IRQ_VALID)
        else $error("pending request not shown");
    slot_address_a: assert property (O_VECTOR_ADDR == {8'h00, O_VECTOR_NUM, 2'b00}
        || O_VECTOR_ADDR == {9'h000, O_VECTOR_NUM, 1'b0}) else $error("slot address not vector scaled");
    no_reserved_a: assert property (O_IRQ_VALID |-> !(O_VECTOR_NUM inside
        {[0:6], [8:11], [17:19], [21:23], 27, 31, 35, 39, [43:51], [56:59], [61:63]}))
        else $error("reserved vector raised");
    lone_pin_a: assert property ($past(I_RST_B) && $past(flat) == 27'h0200000
        |-> O_VECTOR_NUM == 6'h0C) else $error("pin zero vector wrong");
    lone_converter_a: assert property ($past(I_RST_B) && $past(flat) == 27'h0000001
        |-> O_VECTOR_NUM == 6'h3C && !O_IRQ_NMI) else $error("converter vector wrong");
    read_idle_a: assert property (!$past(I_REG_RD) |-> O_REG_RDATA == 8'h00)
        else $error("read data outside read cycle");
    int_cause_a: assert property ($rose(O_INT) |-> $past(I_VEC_ACK) || $past(I_VEC_ACK, 2)
        || $past(I_REG_WR) || $past(I_REG_WR, 2)) else $error("interrupt rose without cause");
endmodule

bind ivp_top ivp_top_properties u_props (
    .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_NMI_REQ(I_NMI_REQ), .I_PIN_REQ(I_PIN_REQ),
    .I_WATCHDOG_REQ(I_WATCHDOG_REQ), .I_TIMER_REQ(I_TIMER_REQ), .I_SERIAL_REQ(I_SERIAL_REQ),
    .I_CONVERTER_REQ(I_CONVERTER_REQ), .I_VEC_ACK(I_VEC_ACK), .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD),
    .O_REG_RDATA(O_REG_RDATA), .O_IRQ_VALID(O_IRQ_VALID), .O_IRQ_NMI(O_IRQ_NMI), .O_IRQ_LEVEL(O_IRQ_LEVEL),
    .O_VECTOR_NUM(O_VECTOR_NUM), .O_VECTOR_ADDR(O_VECTOR_ADDR), .O_INT(O_INT)
);
`default_nettype wire

// ==== test/ivp_core_model.sv ====
// behavioural processor core that takes vectors from the map
`timescale 1ns/100ps
`default_nettype none

module ivp_core_model
    import ivp_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    input  wire logic             i_valid,
    input  wire logic             i_nmi,
    input  wire logic [VEC_W-1:0] i_vec,
    input  wire logic             i_masked,
    input  wire logic [3:0]       i_delay,
    output logic                  o_ack,
    output logic      [VEC_W-1:0] o_taken
);
    logic [3:0] wait_cnt;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_ack    <= 1'b0;
            o_taken  <= '0;
            wait_cnt <= 4'h0;
        end else begin
            o_ack <= 1'b0;
            if (o_ack) begin
                wait_cnt <= 4'h0;
            end else if (i_valid && (i_nmi || !i_masked)) begin
                if (wait_cnt >= i_delay) begin
                    o_ack   <= 1'b1;
                    o_taken <= i_vec;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end else begin
                wait_cnt <= 4'h0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/ivp_top_bench.sv ====
// self-checking bench of the vector priority map
`timescale 1ns/100ps
`default_nettype none

module ivp_top_bench
    import ivp_pkg::*;
();
    logic clk, rst_b, wr, rd, ack, valid, nmi, level, irq, core_masked;
    logic [REG_AW-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, d;
    logic [VEC_W-1:0]  vnum, taken;
    logic [ADDR_W-1:0] vaddr;
    logic [3:0]        core_delay;
    ivp_req_s          req;
    int                mismatches, total_checks;
    logic [5:0]        pv [0:15] = '{6'h20, 6'h1C, 6'h18, 6'h14, 6'h10, 6'h0E, 6'h0D, 6'h0C,
                                     6'h0C, 6'h3C, 6'h0C, 6'h34, 6'h0C, 6'h0C, 6'h28, 6'h24};
    logic [15:0]       lv = 16'hCAFF;

    ivp_top dut_u (.I_CLK(clk), .I_RST_B(rst_b), .I_NMI_REQ(req.nmi), .I_PIN_REQ(req.pin),
        .I_WATCHDOG_REQ(req.watchdog), .I_TIMER_REQ(req.timer), .I_SERIAL_REQ(req.serial),
        .I_CONVERTER_REQ(req.converter), .I_VEC_ACK(ack), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
        .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .O_IRQ_VALID(valid), .O_IRQ_NMI(nmi),
        .O_IRQ_LEVEL(level), .O_VECTOR_NUM(vnum), .O_VECTOR_ADDR(vaddr), .O_INT(irq));
    ivp_core_model core_u (.i_clk(clk), .i_rst_b(rst_b), .i_valid(valid), .i_nmi(nmi), .i_vec(vnum),
        .i_masked(core_masked), .i_delay(core_delay), .o_ack(ack), .o_taken(taken));

    // ********
    // helpers
    // ********
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a; wdata <= v; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic apply(input ivp_req_s r);
        @(posedge clk);
        req <= r;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic check_pick(input logic [5:0] v, input logic l, input logic n, input logic adv);
        check("vector", {10'h000, vnum}, {10'h000, v});
        check("level", {15'h0000, level}, {15'h0000, l});
        check("nmi flag", {15'h0000, nmi}, {15'h0000, n});
        check("address", vaddr, adv ? {8'h00, v, 2'b00} : {9'h000, v, 1'b0});
    endtask
    function automatic ivp_req_s src_req(input int i);
        ivp_req_s r;
        r = '0;
        if (i == 0) r.nmi = 1'b1;
        else if (i < 6) r.pin[i-1] = 1'b1;
        else if (i == 6) r.watchdog = 1'b1;
        else if (i < 22) r.timer[i-7] = 1'b1;
        else if (i < 26) r.serial[i-22] = 1'b1;
        else r.converter = 1'b1;
        return r;
    endfunction
    function automatic ivp_req_s from_req(input int lo);
        ivp_req_s r;
        r = '0;
        for (int j = lo; j < 27; j++) r = r | src_req(j);
        return r;
    endfunction
    function automatic logic [5:0] exp_vec(input int i);
        int t;
        t = i - 7;
        if (i == 0) return 6'h07;
        if (i < 6) return 6'(11 + i);
        if (i == 6) return 6'h14;
        if (i < 22) return 6'(24 + 4 * (t / 3) + t % 3);
        if (i < 26) return 6'(30 + i);
        return 6'h3C;
    endfunction

    // ********
    // scenarios
    // ********
    task automatic t_reset_values();
        reg_rd(REG_PSEL_A); check("select a", {8'h00, d}, 16'h0000);
        reg_rd(REG_PSEL_B); check("select b", {8'h00, d}, 16'h0000);
        reg_rd(REG_CTRL); check("ctrl", {8'h00, d}, 16'h0001);
        reg_rd(4'hF); check("unmapped", {8'h00, d}, 16'h0000);
    endtask
    task automatic t_each_source(input logic adv);
        reg_wr(REG_CTRL, {7'h00, adv});
        for (int i = 0; i < 27; i++) begin
            apply(src_req(i));
            check_pick(exp_vec(i), i == 0, i == 0, adv);
        end
    endtask
    task automatic t_default_order();
        reg_wr(REG_CTRL, 8'h01);
        for (int i = 0; i < 27; i++) begin
            apply(from_req(i));
            check_pick(exp_vec(i), i == 0, i == 0, 1'b1);
        end
    endtask
    task automatic t_promote();
        for (int b = 0; b < 16; b++) begin
            reg_wr(REG_PSEL_A, b < 8 ? 8'(1 << b) : 8'h00);
            reg_wr(REG_PSEL_B, b < 8 ? 8'h00 : 8'(1 << (b - 8)));
            apply(from_req(1));
            check_pick(pv[b], lv[b], 1'b0, 1'b1);
            reg_rd(REG_CUR_VEC); check("current", {8'h00, d}, {8'h00, 1'b1, lv[b], pv[b]});
        end
        reg_wr(REG_PSEL_A, 8'h20);
        reg_wr(REG_PSEL_B, 8'h00);
        apply(src_req(1) | src_req(4));
        check_pick(6'h0F, 1'b1, 1'b0, 1'b1);
        reg_wr(REG_PSEL_A, 8'hFF);
        reg_wr(REG_PSEL_B, 8'hFF);
        apply(from_req(0));
        check_pick(6'h07, 1'b1, 1'b1, 1'b1);
        reg_rd(REG_EVT_STAT); check("nmi taken", {8'h00, d}, 16'h0003);
        reg_rd(REG_PEND_3); check("pending", {8'h00, d}, 16'h0007);
        reg_wr(REG_PSEL_A, 8'h00);
        reg_wr(REG_PSEL_B, 8'h00);
    endtask
    task automatic t_events();
        apply('0);
        reg_wr(REG_EVT_STAT, 8'h07);
        reg_wr(REG_EVT_MASK, 8'h01);
        repeat (2) @(posedge clk);
        #1 check("int idle", {15'h0000, irq}, 16'h0000);
        core_masked <= 1'b0;
        core_delay <= 4'h3;
        apply(src_req(7));
        repeat (8) @(posedge clk);
        req <= '0;
        core_masked <= 1'b1;
        repeat (3) @(posedge clk);
        #1 check("int raised", {15'h0000, irq}, 16'h0001);
        check("core vector", {10'h000, taken}, 16'h0018);
        reg_rd(REG_LAST_VEC); check("last taken", {8'h00, d}, 16'h0098);
        reg_rd(REG_EVT_STAT); check("taken event", {15'h0000, d[EVT_TAKEN]}, 16'h0001);
        reg_wr(REG_EVT_MASK, 8'h00);
        repeat (2) @(posedge clk);
        #1 check("int masked", {15'h0000, irq}, 16'h0000);
        reg_wr(REG_EVT_STAT, 8'h07);
        reg_wr(REG_EVT_MASK, 8'h01);
        repeat (2) @(posedge clk);
        #1 check("int cleared", {15'h0000, irq}, 16'h0000);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
    initial begin
        rst_b = 1'b0; req = '0; addr = '0; wdata = '0; wr = 1'b0; rd = 1'b0;
        core_masked = 1'b1; core_delay = 4'h0; mismatches = 0; total_checks = 0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_reset_values();
        t_default_order();
        t_each_source(1'b0);
        t_each_source(1'b1);
        t_promote();
        t_events();
        wrap_up();
    end
endmodule
`default_nettype wire
